// ### core/piiw_cfg.svh
// constants for the interrupt controller and idle wake logic
`ifndef PIIW_CFG_SVH
`define PIIW_CFG_SVH

// special-function byte addresses
`define PIIW_ADDR_SYSCTL2 8'h39
`define PIIW_ADDR_ENABLE_LO 8'h3A
`define PIIW_ADDR_ENABLE_HI 8'h3B
`define PIIW_ADDR_PENDING_LO 8'h3C
`define PIIW_ADDR_PENDING_HI 8'h3D

// field positions
`define PIIW_HALT_BIT 4
`define PIIW_MASTER_BIT 0
`define PIIW_IDX_SOFT_TRAP 4'h1
`define PIIW_IDX_WATCHDOG 4'h2
`define PIIW_IDX_EXT_ZERO 4'h3

// reset values and fixed masks
`define PIIW_PENDING_RST 16'h0000
`define PIIW_ENABLE_RST 16'h0000
`define PIIW_PENDING_MASK 16'hFFFC
`define PIIW_ENABLE_MASK 16'hFFF1
`define PIIW_SYSCTL2_RD_ONES 8'h0F

// vector table top and spacing
`define PIIW_VECTOR_TOP 16'hFFFE
`define PIIW_VECTOR_STEP 16'h0002

// timing
`define PIIW_ACCEPT_MCYC 4'h8
`define PIIW_MCYC_CLKS 4

`endif

// ### core/piiw_pkg.sv
// types shared by the interrupt controller files
package piiw_pkg;

    typedef enum logic [5:0] {
        PIIW_RUN_SINGLE  = 6'h01,
        PIIW_RUN_DUAL    = 6'h02,
        PIIW_RUN_LOW     = 6'h04,
        PIIW_HALT_SINGLE = 6'h08,
        PIIW_HALT_DUAL   = 6'h10,
        PIIW_SLEEP_LOW   = 6'h20
    } piiw_power_t;

    typedef enum logic [1:0] {
        PIIW_ACC_IDLE = 2'h1,
        PIIW_ACC_SEQ  = 2'h2
    } piiw_acc_t;

endpackage

// ### core/piiw_arb_if.sv
// carrier between the controller and its priority arbiter
`timescale 1ns/1ps
interface piiw_arb_if;
    logic [15:0] pending;
    logic [15:0] enables;
    logic ext_zero_en;
    logic soft_trap;
    logic nmi_busy;
    logic win_valid;
    logic [3:0] win_idx;
    logic [15:0] win_vector;
    logic wake;

    modport ctrl (output pending, output enables, output ext_zero_en, output soft_trap,
                  output nmi_busy, input win_valid, input win_idx, input win_vector, input wake);
    modport arb (input pending, input enables, input ext_zero_en, input soft_trap,
                 input nmi_busy, output win_valid, output win_idx, output win_vector, output wake);
endinterface

// ### core/piiw_arbiter.sv
// fixed priority arbiter, vector lookup and idle wake detect
`timescale 1ns/1ps
`include "piiw_cfg.svh"
module piiw_arbiter (
    piiw_arb_if.arb arb
);
    function automatic logic [15:0] vec_of(input logic [3:0] idx);
        vec_of = `PIIW_VECTOR_TOP - (16'(idx) * `PIIW_VECTOR_STEP);
    endfunction

    wire master_enable = arb.enables[`PIIW_MASTER_BIT];
    wire [15:0] masked_ok;
    wire [15:0] wake_ok;
    logic [15:0] req;
    logic [3:0] idx;
    logic found;

    // maskable needs master and own flag; ext zero uses its own enable
    assign masked_ok = arb.pending & arb.enables & {16{master_enable}};
    assign wake_ok = arb.pending & arb.enables;

    always_comb begin
        req = masked_ok & `PIIW_PENDING_MASK;
        req[`PIIW_IDX_EXT_ZERO] = arb.pending[`PIIW_IDX_EXT_ZERO] & master_enable & arb.ext_zero_en;
        // pseudo non-maskable ignore enables but wait for running one
        req[`PIIW_IDX_SOFT_TRAP] = arb.soft_trap & ~arb.nmi_busy;
        req[`PIIW_IDX_WATCHDOG] = arb.pending[`PIIW_IDX_WATCHDOG] & ~arb.nmi_busy;
        req[0] = 1'b0;
        idx = 4'h0;
        found = 1'b0;
        // lowest index wins
        for (int i = 15; i >= 1; i--) begin
            if (req[i]) begin
                idx = 4'(i);
                found = 1'b1;
            end
        end
    end

    assign arb.win_valid = found;
    assign arb.win_idx = idx;
    // one vector word per source
    assign arb.win_vector = vec_of(idx);
    // enabled source or ext zero ends halt
    assign arb.wake = |(wake_ok & 16'hFFF0) | arb.pending[`PIIW_IDX_EXT_ZERO];
endmodule

// ### core/piiw_ctrl.sv
// interrupt controller top with pending latches, enables, acceptance and idle wake
//
// Summary of operation
// - fifteen sources at indices one to fifteen, each latched except the software trap
// - software trap and watchdog are pseudo non-maskable, the rest maskable
// - latch sets on request, hardware clears it right after acceptance
// - reset forces every pending latch to zero
// - software writes can only clear latches, bit by bit, never set
// - pending latches sit at two bytes and are readable
// - enable word sits at two bytes, readable and writable, bits one to three fixed at zero
// - maskable accepted only with master enable and own enable both set
// - pseudo non-maskable accepted regardless of enables
// - a pseudo non-maskable request waits while another one is in service
// - several pending requests resolve to the highest priority first
// - fixed priority 0 to 15 from reset down to external five
// - each source has its own vector word, two bytes apart, descending
// - halt bit stops cpu and watchdog, peripherals keep running
// - halt with master off ends on enabled source, resumes without service
// - halt with master on ends on enabled source and starts service
// - ending a halt returns to the run mode it came from
// - reset during halt ends it at once with full reset
// - watchdog request just before halt write wins, halt not entered
// - master enable is bit zero of low enable byte, reset to zero
// - maskable acceptance clears master enable, maskable return sets it
// - acceptance takes eight machine cycles after the current instruction
// - ext zero latch is not set by edges while its enable is zero
`timescale 1ns/1ps
`include "piiw_cfg.svh"
module piiw_ctrl #(
    parameter int MCYC_CLKS = `PIIW_MCYC_CLKS
) (
    input wire logic sys_clk_in,
    input wire logic srst_in,
    input wire logic [7:0] sfr_addr_in,
    input wire logic sfr_wr_in,
    input wire logic sfr_rd_in,
    input wire logic [7:0] sfr_wdata_in,
    output logic [7:0] sfr_rdata_out,
    input wire logic [15:0] src_req_in,
    input wire logic ext_zero_pin_in,
    input wire logic ext_zero_enable_in,
    input wire logic soft_trap_in,
    input wire logic core_sample_in,
    input wire logic maskable_return_in,
    input wire logic nmi_return_in,
    input wire logic low_clock_in,
    input wire logic dual_clock_in,
    output logic int_pending_out,
    output logic accept_busy_out,
    output logic vector_valid_out,
    output logic [15:0] vector_addr_out,
    output logic [3:0] accepted_src_out,
    output logic cpu_halt_out,
    output logic wdt_halt_out,
    output logic wake_resume_out,
    output piiw_pkg::piiw_power_t power_mode_out
);
    piiw_arb_if arb_bus ();

    logic [15:0] pending_q, pending_d;
    logic [15:0] enable_q, enable_d;
    logic nmi_busy_q;
    logic nmi_imf_q;
    logic halt_q;
    logic [2:0] pin_sync_q;
    piiw_pkg::piiw_acc_t acc_q;
    logic [3:0] mcyc_cnt_q;
    logic [3:0] div_cnt_q;
    logic [3:0] win_idx_q;
    logic win_nmi_q;
    logic [15:0] win_vec_q;
    piiw_pkg::piiw_power_t mode_q;
    logic [7:0] rdata_q;
    logic int_pend_q, busy_q, vvalid_q, wake_res_q;
    logic [15:0] vaddr_q;
    logic [3:0] asrc_q;

    piiw_arbiter u_arb (
        .arb(arb_bus)
    );

    assign arb_bus.pending = pending_q;
    assign arb_bus.enables = enable_q;
    assign arb_bus.ext_zero_en = ext_zero_enable_in;
    assign arb_bus.soft_trap = soft_trap_in;
    assign arb_bus.nmi_busy = nmi_busy_q;

    // bus decode
    wire wr_pend_lo = sfr_wr_in & (sfr_addr_in == `PIIW_ADDR_PENDING_LO);
    wire wr_pend_hi = sfr_wr_in & (sfr_addr_in == `PIIW_ADDR_PENDING_HI);
    wire wr_en_lo = sfr_wr_in & (sfr_addr_in == `PIIW_ADDR_ENABLE_LO);
    wire wr_en_hi = sfr_wr_in & (sfr_addr_in == `PIIW_ADDR_ENABLE_HI);
    wire wr_sys2 = sfr_wr_in & (sfr_addr_in == `PIIW_ADDR_SYSCTL2);
    wire halt_wr = wr_sys2 & sfr_wdata_in[`PIIW_HALT_BIT];

    // falling edge of the synchronised ext zero pin
    wire ext_zero_fall = pin_sync_q[2] & ~pin_sync_q[1];

    // machine cycle enable from a divider
    wire mcyc_en = (div_cnt_q == 4'(MCYC_CLKS - 1));

    // take the winner at the instruction's last cycle, not while halted
    wire accept_now = (acc_q == piiw_pkg::PIIW_ACC_IDLE) & core_sample_in & arb_bus.win_valid & ~halt_q;
    wire win_is_nmi = (arb_bus.win_idx == `PIIW_IDX_SOFT_TRAP) | (arb_bus.win_idx == `PIIW_IDX_WATCHDOG);
    wire seq_done = (acc_q == piiw_pkg::PIIW_ACC_SEQ) & mcyc_en & (mcyc_cnt_q == `PIIW_ACCEPT_MCYC - 4'h1);

    // halt entry is refused when the watchdog latch is already up
    wire halt_enter = halt_wr & ~halt_q & ~pending_q[`PIIW_IDX_WATCHDOG] & ~src_req_in[`PIIW_IDX_WATCHDOG];
    wire halt_exit = halt_q & arb_bus.wake;

    // set sources for the pending latches
    logic [15:0] set_vec;
    logic [15:0] wr_keep;
    logic [15:0] acc_clr;
    always_comb begin
        set_vec = src_req_in & `PIIW_PENDING_MASK;
        // ext zero edges only count while its enable is on
        set_vec[`PIIW_IDX_EXT_ZERO] = ext_zero_fall & ext_zero_enable_in;
        // writes of zero clear, ones keep, never set
        wr_keep = 16'hFFFF;
        if (wr_pend_lo) begin
            wr_keep[7:0] = sfr_wdata_in;
        end
        if (wr_pend_hi) begin
            wr_keep[15:8] = sfr_wdata_in;
        end
        acc_clr = 16'hFFFF;
        if (accept_now) begin
            acc_clr[arb_bus.win_idx] = 1'b0;
        end
    end

    // set wins over any clear in the same cycle
    assign pending_d = ((pending_q & wr_keep & acc_clr) | set_vec) & `PIIW_PENDING_MASK;

    // enable word with master flag handling
    logic master_d;
    always_comb begin
        enable_d = enable_q;
        if (wr_en_lo) begin
            enable_d[7:0] = sfr_wdata_in;
        end
        if (wr_en_hi) begin
            enable_d[15:8] = sfr_wdata_in;
        end
        master_d = enable_d[`PIIW_MASTER_BIT];
        if (maskable_return_in) begin
            master_d = 1'b1;
        end
        if (nmi_return_in & nmi_imf_q) begin
            master_d = 1'b1;
        end
        if (accept_now) begin
            master_d = 1'b0;
        end
        enable_d[`PIIW_MASTER_BIT] = master_d;
        enable_d = enable_d & `PIIW_ENABLE_MASK;
    end

    // read data mux
    logic [7:0] rdata_d;
    always_comb begin
        unique case (sfr_addr_in)
            `PIIW_ADDR_PENDING_LO: rdata_d = pending_q[7:0];
            `PIIW_ADDR_PENDING_HI: rdata_d = pending_q[15:8];
            `PIIW_ADDR_ENABLE_LO: rdata_d = enable_q[7:0];
            `PIIW_ADDR_ENABLE_HI: rdata_d = enable_q[15:8];
            `PIIW_ADDR_SYSCTL2: rdata_d = {3'h0, halt_q, 4'h0} | `PIIW_SYSCTL2_RD_ONES;
            default: rdata_d = 8'h00;
        endcase
    end

    // run mode the halt returns to
    wire [5:0] run_mode = low_clock_in ? piiw_pkg::PIIW_RUN_LOW :
                          (dual_clock_in ? piiw_pkg::PIIW_RUN_DUAL : piiw_pkg::PIIW_RUN_SINGLE);
    piiw_pkg::piiw_power_t mode_d;
    always_comb begin
        mode_d = piiw_pkg::piiw_power_t'(run_mode);
        if (halt_enter) begin
            unique case (piiw_pkg::piiw_power_t'(run_mode))
                piiw_pkg::PIIW_RUN_LOW: mode_d = piiw_pkg::PIIW_SLEEP_LOW;
                piiw_pkg::PIIW_RUN_DUAL: mode_d = piiw_pkg::PIIW_HALT_DUAL;
                default: mode_d = piiw_pkg::PIIW_HALT_SINGLE;
            endcase
        end else if (halt_q & ~halt_exit) begin
            mode_d = mode_q;
        end else if (halt_exit) begin
            // return to the run mode the halt was entered from
            unique case (mode_q)
                piiw_pkg::PIIW_SLEEP_LOW: mode_d = piiw_pkg::PIIW_RUN_LOW;
                piiw_pkg::PIIW_HALT_DUAL: mode_d = piiw_pkg::PIIW_RUN_DUAL;
                default: mode_d = piiw_pkg::PIIW_RUN_SINGLE;
            endcase
        end
    end

    // latches and enables, reset forces zero
    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            pending_q <= `PIIW_PENDING_RST;
            enable_q <= `PIIW_ENABLE_RST;
            pin_sync_q <= 3'h7;
        end else begin
            pending_q <= pending_d;
            enable_q <= enable_d;
            pin_sync_q <= {pin_sync_q[1:0], ext_zero_pin_in};
        end
    end

    // acceptance sequence of eight machine cycles
    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            acc_q <= piiw_pkg::PIIW_ACC_IDLE;
            mcyc_cnt_q <= 4'h0;
            div_cnt_q <= 4'h0;
            win_idx_q <= 4'h0;
            win_vec_q <= 16'h0000;
            win_nmi_q <= 1'b0;
        end else begin
            div_cnt_q <= mcyc_en ? 4'h0 : div_cnt_q + 4'h1;
            unique case (acc_q)
                piiw_pkg::PIIW_ACC_IDLE: begin
                    if (accept_now) begin
                        acc_q <= piiw_pkg::PIIW_ACC_SEQ;
                        mcyc_cnt_q <= 4'h0;
                        win_idx_q <= arb_bus.win_idx;
                        win_vec_q <= arb_bus.win_vector;
                        win_nmi_q <= win_is_nmi;
                    end
                end
                piiw_pkg::PIIW_ACC_SEQ: begin
                    if (seq_done) begin
                        acc_q <= piiw_pkg::PIIW_ACC_IDLE;
                    end else if (mcyc_en) begin
                        mcyc_cnt_q <= mcyc_cnt_q + 4'h1;
                    end
                end
            endcase
        end
    end

    // pseudo non-maskable service tracking
    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            nmi_busy_q <= 1'b0;
            nmi_imf_q <= 1'b0;
        end else if (accept_now & win_is_nmi) begin
            nmi_busy_q <= 1'b1;
            nmi_imf_q <= enable_q[`PIIW_MASTER_BIT];
        end else if (nmi_return_in) begin
            nmi_busy_q <= 1'b0;
        end
    end

    // halt entry and exit
    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            halt_q <= 1'b0;
            mode_q <= piiw_pkg::PIIW_RUN_SINGLE;
            wake_res_q <= 1'b0;
        end else begin
            mode_q <= mode_d;
            wake_res_q <= halt_exit & ~enable_q[`PIIW_MASTER_BIT];
            if (halt_enter) begin
                halt_q <= 1'b1;
            end else if (halt_exit) begin
                halt_q <= 1'b0;
            end
        end
    end

    // registered outputs toward the core
    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            rdata_q <= 8'h00;
            int_pend_q <= 1'b0;
            busy_q <= 1'b0;
            vvalid_q <= 1'b0;
            vaddr_q <= 16'h0000;
            asrc_q <= 4'h0;
        end else begin
            rdata_q <= sfr_rd_in ? rdata_d : 8'h00;
            int_pend_q <= arb_bus.win_valid;
            busy_q <= (acc_q == piiw_pkg::PIIW_ACC_SEQ) & ~seq_done;
            vvalid_q <= seq_done;
            if (seq_done) begin
                vaddr_q <= win_vec_q;
                asrc_q <= win_idx_q;
            end
        end
    end

    assign sfr_rdata_out = rdata_q;
    assign int_pending_out = int_pend_q;
    assign accept_busy_out = busy_q;
    assign vector_valid_out = vvalid_q;
    assign vector_addr_out = vaddr_q;
    assign accepted_src_out = asrc_q;
    assign cpu_halt_out = halt_q;
    assign wdt_halt_out = halt_q;
    assign wake_resume_out = wake_res_q;
    assign power_mode_out = mode_q;
endmodule

// ### tb/piiw_ctrl_asserts.sv
// concurrent checks on the interrupt controller top ports
`timescale 1ns/1ps
module piiw_ctrl_asserts #(
    parameter int MCYC_CLKS = 4
) (
    input wire logic sys_clk_in,
    input wire logic srst_in,
    input wire logic [7:0] sfr_addr_in,
    input wire logic sfr_wr_in,
    input wire logic sfr_rd_in,
    input wire logic [7:0] sfr_wdata_in,
    input wire logic [7:0] sfr_rdata_out,
    input wire logic accept_busy_out,
    input wire logic vector_valid_out,
    input wire logic [15:0] vector_addr_out,
    input wire logic [3:0] accepted_src_out,
    input wire logic cpu_halt_out,
    input wire logic wdt_halt_out,
    input wire logic wake_resume_out,
    input wire piiw_pkg::piiw_power_t power_mode_out
);
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (srst_in);
    a_accept_length: assert property ($rose(accept_busy_out) |->
        accept_busy_out[*8] ##[21:25] vector_valid_out)
        else $error("acceptance length wrong");
    a_vector_pulse: assert property (vector_valid_out |=> !vector_valid_out)
        else $error("vector valid longer than one cycle");
    a_vector_map: assert property (vector_valid_out |->
        vector_addr_out == 16'hFFFE - {11'h000, accepted_src_out, 1'b0})
        else $error("vector address does not match source");
    a_rdata_quiet: assert property (!sfr_rd_in |=> sfr_rdata_out == 8'h00)
        else $error("read data without read strobe");
    a_reset_state: assert property ($fell(srst_in) |->
        power_mode_out == piiw_pkg::PIIW_RUN_SINGLE && !cpu_halt_out)
        else $error("state after reset wrong");
    a_halt_start: assert property ($rose(cpu_halt_out) |->
        $past(sfr_wr_in && sfr_addr_in == 8'h39 && sfr_wdata_in[4]))
        else $error("halt without halt write");
    a_halt_pair: assert property (cpu_halt_out |-> wdt_halt_out && !accept_busy_out)
        else $error("watchdog not halted with cpu");
    a_halt_mode: assert property (cpu_halt_out |-> power_mode_out inside {piiw_pkg::PIIW_HALT_SINGLE,
        piiw_pkg::PIIW_HALT_DUAL, piiw_pkg::PIIW_SLEEP_LOW})
        else $error("halted in a run mode");
    a_wake_resume: assert property (wake_resume_out |-> !cpu_halt_out && $past(cpu_halt_out))
        else $error("resume pulse without halt end");
    a_mode_back: assert property ($fell(cpu_halt_out) && !$past(srst_in) |->
        power_mode_out == ($past(power_mode_out) == piiw_pkg::PIIW_HALT_DUAL ? piiw_pkg::PIIW_RUN_DUAL :
        $past(power_mode_out) == piiw_pkg::PIIW_SLEEP_LOW ? piiw_pkg::PIIW_RUN_LOW : piiw_pkg::PIIW_RUN_SINGLE))
        else $error("wrong run mode after halt");
    c_vector: cover property (vector_valid_out);
    c_soft_trap: cover property (vector_valid_out && accepted_src_out == 4'h1);
    c_resume: cover property (wake_resume_out);
    c_halt: cover property ($rose(cpu_halt_out));
endmodule
bind piiw_ctrl piiw_ctrl_asserts #(.MCYC_CLKS(MCYC_CLKS)) u_piiw_ctrl_asserts (.sys_clk_in, .srst_in, .sfr_addr_in,
    .sfr_wr_in, .sfr_rd_in, .sfr_wdata_in, .sfr_rdata_out, .accept_busy_out, .vector_valid_out, .vector_addr_out,
    .accepted_src_out, .cpu_halt_out, .wdt_halt_out, .wake_resume_out, .power_mode_out);

// ### tb/piiw_core_model.sv
// behavioural cpu core: instruction ends, service time and return
`timescale 1ns/1ps
module piiw_core_model #(
    parameter int SVC_CLKS = 16
) (
    input wire logic clk_in,
    input wire logic srst_in,
    input wire logic run_in,
    input wire logic vector_valid_in,
    input wire logic [3:0] accepted_src_in,
    output logic core_sample_out,
    output logic maskable_return_out,
    output logic nmi_return_out
);
    logic [1:0] div_q;
    int svc_q;
    // requests are sampled at every instruction end, inside service routines too
    assign core_sample_out = run_in && div_q == 2'h3;
    always_ff @(posedge clk_in) begin
        div_q <= srst_in ? 2'h0 : div_q + 2'h1;
        svc_q <= srst_in ? 0 : vector_valid_in ? SVC_CLKS : svc_q > 0 ? svc_q - 1 : 0;
        maskable_return_out <= !srst_in && svc_q == 1 && accepted_src_in > 4'h2;
        nmi_return_out <= !srst_in && svc_q == 1 && accepted_src_in < 4'h3;
    end
endmodule

// ### tb/tb_piiw_ctrl.sv
// self-checking bench for the interrupt controller
`timescale 1ns/1ps
module tb_piiw_ctrl;
    logic sys_clk_in, srst_in, sfr_wr_in, sfr_rd_in, ext_zero_pin_in, ext_zero_enable_in, soft_trap_in;
    logic low_clock_in, dual_clock_in, run_core, core_sample_in, maskable_return_in, nmi_return_in;
    logic [7:0] sfr_addr_in, sfr_wdata_in, sfr_rdata_out;
    logic [15:0] src_req_in, vector_addr_out;
    logic [3:0] accepted_src_out;
    logic int_pending_out, accept_busy_out, vector_valid_out, cpu_halt_out, wdt_halt_out, wake_resume_out;
    piiw_pkg::piiw_power_t power_mode_out;
    int err_total, checks_done;
    piiw_ctrl u_piiw_ctrl (.sys_clk_in, .srst_in, .sfr_addr_in, .sfr_wr_in, .sfr_rd_in, .sfr_wdata_in,
        .sfr_rdata_out, .src_req_in, .ext_zero_pin_in, .ext_zero_enable_in, .soft_trap_in, .core_sample_in,
        .maskable_return_in, .nmi_return_in, .low_clock_in, .dual_clock_in, .int_pending_out, .accept_busy_out,
        .vector_valid_out, .vector_addr_out, .accepted_src_out, .cpu_halt_out, .wdt_halt_out, .wake_resume_out,
        .power_mode_out);
    piiw_core_model u_piiw_core_model (.clk_in(sys_clk_in), .srst_in, .run_in(run_core),
        .vector_valid_in(vector_valid_out), .accepted_src_in(accepted_src_out), .core_sample_out(core_sample_in),
        .maskable_return_out(maskable_return_in), .nmi_return_out(nmi_return_in));
    initial begin
        sys_clk_in = 1'b0;
        forever #5 sys_clk_in = ~sys_clk_in;
    end
    task automatic chk(input string n, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch %s exp %h seen %h", n, exp, seen);
        end
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk_in);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk_in);
        sfr_addr_in <= a;
        sfr_wdata_in <= d;
        sfr_wr_in <= 1'b1;
        @(posedge sys_clk_in);
        sfr_wr_in <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge sys_clk_in);
        sfr_addr_in <= a;
        sfr_rd_in <= 1'b1;
        @(posedge sys_clk_in);
        sfr_rd_in <= 1'b0;
        #1;
        chk("rdata", {8'h00, sfr_rdata_out}, {8'h00, e});
    endtask
    task automatic req(input logic [15:0] b);
        @(posedge sys_clk_in);
        src_req_in <= b;
        @(posedge sys_clk_in);
        src_req_in <= 16'h0000;
    endtask
    task automatic wait_lvl(ref logic sig, input logic lvl);
        int i;
        for (i = 0; i < 300 && sig !== lvl; i++) begin
            @(posedge sys_clk_in);
            #1;
        end
        if (i == 300) begin
            err_total++;
            end_sim();
        end
    endtask
    task automatic wait_vec(input logic [3:0] s);
        @(posedge sys_clk_in);
        wait_lvl(vector_valid_out, 1'b1);
        chk("vector", vector_addr_out, 16'hFFFE - {11'h000, s, 1'b0});
        chk("source", {12'h000, accepted_src_out}, {12'h000, s});
    endtask
    task automatic run(input logic v);
        @(posedge sys_clk_in);
        run_core <= v;
    endtask
    logic [3:0] order [3] = '{4'h6, 4'h9, 4'hF};
    initial begin
        err_total = 0;
        checks_done = 0;
        {srst_in, sfr_wr_in, sfr_rd_in, ext_zero_enable_in, soft_trap_in, low_clock_in, dual_clock_in} = 7'h40;
        {run_core, sfr_addr_in, sfr_wdata_in, src_req_in} = 33'h0;
        ext_zero_pin_in = 1'b1;
        cyc(10);
        srst_in <= 1'b0;
        rd(8'h3A, 8'h00);
        rd(8'h3C, 8'h00);
        rd(8'h3D, 8'h00);
        rd(8'h39, 8'h0F);
        rd(8'h40, 8'h00);
        wr(8'h3A, 8'hFF);
        rd(8'h3A, 8'hF1);
        wr(8'h3B, 8'hFF);
        rd(8'h3B, 8'hFF);
        $display("test registers done");
        req(16'h8240);
        rd(8'h3C, 8'h40);
        rd(8'h3D, 8'h82);
        chk("pending", {15'h0, int_pending_out}, 16'h0001);
        run(1'b1);
        for (int k = 0; k < 3; k++) begin
            wait_vec(order[k]);
            rd(8'h3A, 8'hF0);
        end
        cyc(24);
        rd(8'h3A, 8'hF1);
        rd(8'h3C, 8'h00);
        rd(8'h3D, 8'h00);
        $display("test priority done");
        wr(8'h3A, 8'hF0);
        req(16'h0080);
        cyc(60);
        chk("pending", {15'h0, int_pending_out}, 16'h0000);
        rd(8'h3C, 8'h80);
        wr(8'h3C, 8'h7F);
        rd(8'h3C, 8'h00);
        wr(8'h3C, 8'hFF);
        rd(8'h3C, 8'h00);
        run(1'b0);
        ext_zero_pin_in <= 1'b0;
        cyc(4);
        rd(8'h3C, 8'h00);
        @(posedge sys_clk_in);
        ext_zero_pin_in <= 1'b1;
        ext_zero_enable_in <= 1'b1;
        cyc(4);
        ext_zero_pin_in <= 1'b0;
        cyc(4);
        rd(8'h3C, 8'h08);
        wr(8'h3C, 8'hF7);
        rd(8'h3C, 8'h00);
        $display("test masking done");
        wr(8'h3A, 8'h00);
        wr(8'h3B, 8'h00);
        req(16'h0004);
        run(1'b1);
        wait_vec(4'h2);
        @(posedge sys_clk_in);
        soft_trap_in <= 1'b1;
        cyc(13);
        #1;
        chk("busy", {15'h0, accept_busy_out}, 16'h0000);
        wait_vec(4'h1);
        run(1'b0);
        soft_trap_in <= 1'b0;
        cyc(20);
        req(16'h0004);
        wr(8'h39, 8'h10);
        chk("halt", {15'h0, cpu_halt_out}, 16'h0000);
        run(1'b1);
        wait_vec(4'h2);
        run(1'b0);
        cyc(20);
        $display("test nmi done");
        wr(8'h3A, 8'h20);
        wr(8'h39, 8'h10);
        chk("halt", {15'h0, cpu_halt_out}, 16'h0001);
        chk("mode", {10'h0, power_mode_out}, 16'h0008);
        req(16'h0020);
        wait_lvl(cpu_halt_out, 1'b0);
        chk("resume", {15'h0, wake_resume_out}, 16'h0001);
        chk("mode", {10'h0, power_mode_out}, 16'h0001);
        wr(8'h3C, 8'hDF);
        rd(8'h3C, 8'h00);
        wr(8'h3A, 8'h21);
        wr(8'h39, 8'h10);
        run(1'b1);
        req(16'h0020);
        wait_vec(4'h5);
        chk("halt", {15'h0, cpu_halt_out}, 16'h0000);
        run(1'b0);
        cyc(20);
        dual_clock_in <= 1'b1;
        wr(8'h39, 8'h10);
        chk("mode", {10'h0, power_mode_out}, 16'h0010);
        @(posedge sys_clk_in);
        srst_in <= 1'b1;
        dual_clock_in <= 1'b0;
        cyc(2);
        srst_in <= 1'b0;
        #1;
        chk("halt", {15'h0, cpu_halt_out}, 16'h0000);
        chk("mode", {10'h0, power_mode_out}, 16'h0001);
        rd(8'h3A, 8'h00);
        $display("test halt done");
        end_sim();
    end
endmodule
